// ---- design/mir_pkg.sv ----
package mir_pkg;

  // register offsets on the serial port
  localparam logic [6:0] ADDR_STATUS  = 7'h01;
  localparam logic [6:0] ADDR_Y       = 7'h02;
  localparam logic [6:0] ADDR_X       = 7'h03;
  localparam logic [6:0] ADDR_SURFACE = 7'h04;
  localparam logic [6:0] ADDR_PEAK    = 7'h05;
  localparam logic [6:0] ADDR_DARK    = 7'h06;
  localparam logic [6:0] ADDR_TOTAL   = 7'h07;
  localparam logic [6:0] ADDR_GRAB    = 7'h08;

  // reset values
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [5:0] RST_DARK  = 6'h3F;
  localparam logic [7:0] UNMAPPED  = 8'h00;

  // status layout: part code in 7:5, awake in 0
  localparam int unsigned STAT_CODE_LSB = 5;
  localparam logic [3:0]  STAT_RSVD     = 4'h0;

  // motion count limits, two's complement
  localparam logic [7:0] MOT_MIN = 8'h80;
  localparam logic [7:0] MOT_MAX = 8'h7F;

  // frame geometry: pixel numbers 1..324 held as 0..323
  localparam logic [8:0] PIX_FIRST = 9'h000;
  localparam logic [8:0] PIX_LAST  = 9'h143;

  // pixel grab layout
  localparam int unsigned GRAB_FIRST_BIT = 7;
  localparam int unsigned GRAB_READY_BIT = 6;

  // sleep after one second without movement at the nominal frame rate
  localparam int unsigned SLEEP_TIME_MS = 1000;
  localparam int unsigned FRAME_RATE    = 1500;
  localparam logic [10:0] SLEEP_FRAMES  = 11'(SLEEP_TIME_MS * FRAME_RATE / 1000);

  // serial frame: 8 address bits, then 8 data bits
  localparam logic [3:0] BIT_ADDR_LAST = 4'h7;
  localparam logic [3:0] BIT_WR_LAST   = 4'hF;
  localparam logic [3:0] BIT_ONE       = 4'h1;

endpackage

// ---- design/mir_readout.sv ----
// Summary of operation
// - status reads part code in bits 7:5 and awake flag in bit 0
// - y_motion_count at 0x02 accumulates vertical motion since last read
// - x_motion_count at 0x03 accumulates horizontal motion since last read
// - reading a motion count returns it and then clears it
// - motion counts are eight-bit two's complement, saturating at 80 and 7F
// - surface_feature_count at 0x04 holds upper eight bits of nine-bit count
// - surface_feature_count stays within 255 and updates every frame
// - peak_intensity holds the frame's largest pixel, six bits, upper bits zero
// - darkest_intensity at 0x06 holds smallest pixel, resets to 0x3F
// - intensity_total holds the fifteen-bit pixel sum divided by 128
// - intensity_total never exceeds 159
// - pixel_grab at 0x08: first flag bit 7, ready bit 6, sample 5:0
// - first flag marks pixel number 1; ready flag marks valid grabbed data
// - any write to pixel_grab restarts the grabber at pixel 1
// - each read of pixel_grab that finds the ready flag set advances to the next pixel
// - after pixel 324 the grabber wraps back to pixel 1
// - at most one pixel is grabbed per frame
// - any pixel_grab access arms capture from the next frame; held until read or written
// - stay_active_bit keeps awake; otherwise sleep after one second idle
`timescale 1ns/10ps
module mir_readout
  import mir_pkg::*;
#(
  parameter logic [2:0] PART_CODE = 3'h5  // arbitrary value
) (
  // system
  input  wire logic       mclk,
  input  wire logic       rst,
  // serial port
  input  wire logic       sck,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe_n,
  // configuration
  input  wire logic       stay_active_bit,
  // imaging pipeline
  input  wire logic       pix_valid,
  input  wire logic [5:0] pix_value,
  input  wire logic [8:0] feature_total,
  // motion engine
  input  wire logic       motion_valid,
  input  wire logic [7:0] motion_dx,
  input  wire logic [7:0] motion_dy,
  // state
  output logic            sensor_awake
);

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [6:0] addr;
    logic       rd_phase;
    logic [7:0] wdata;
    logic       rd_tog;
    logic       wr_tog;
  } mir_link_t;

  typedef struct packed {
    logic        rs1, rs2, rs3;
    logic        ws1, ws2, ws3;
    logic [7:0]  rd_data;
    logic [7:0]  y, x;
    logic [8:0]  pidx;
    logic [5:0]  run_max, run_min;
    logic [14:0] run_sum;
    logic [7:0]  surface, total;
    logic [5:0]  peak, dark;
    logic [8:0]  gidx;
    logic        pend, armed, ready, gfirst;
    logic [5:0]  sample;
    logic [10:0] idle;
    logic        awake;
  } mir_core_t;

  mir_link_t k_q, k_d;
  mir_core_t s_q, s_d;
  logic      out_q, oe_n_q;
  logic      rd_go, wr_go, rd_y, rd_x, grab_rd, grab_wr, commit, moving;
  logic [7:0] sh;

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = {a[7], a} + {b[7], b};
    if (t[8] != t[7]) begin
      sat_add = t[8] ? MOT_MIN : MOT_MAX;
    end else begin
      sat_add = t[7:0];
    end
  endfunction

  // ---------------- link domain, clocked by sck ----------------
  always_comb begin
    k_d = k_q;
    sh  = {k_q.shift[6:0], sdio_in};
    k_d.shift = sh;
    k_d.cnt = k_q.cnt + BIT_ONE;
    if (k_q.rd_phase) begin
      if (k_q.cnt == BIT_ADDR_LAST) begin
        k_d.rd_phase = 1'b0;
        k_d.cnt      = 4'h0;
      end
    end else if (k_q.cnt == BIT_ADDR_LAST) begin
      k_d.addr = sh[6:0];
      if (!sh[7]) begin
        k_d.rd_phase = 1'b1;
        k_d.cnt      = 4'h0;
        k_d.rd_tog   = ~k_q.rd_tog;
      end
    end else if (k_q.cnt == BIT_WR_LAST) begin
      k_d.wdata  = sh;
      k_d.wr_tog = ~k_q.wr_tog;
      k_d.cnt    = 4'h0;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      k_q <= '0;
    end else begin
      k_q <= k_d;
    end
  end

  // data leaves on the falling edge; rd_data settles within a few mclk cycles
  // of the address, well before the first falling edge at link rate
  always_ff @(negedge sck or posedge rst) begin
    if (rst) begin
      out_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= ~k_q.rd_phase;
      out_q  <= s_q.rd_data[~k_q.cnt[2:0]];
    end
  end

  assign sdio_out     = out_q;
  assign sdio_oe_n    = oe_n_q;
  assign sensor_awake = s_q.awake;

  // ---------------- core domain, clocked by mclk ----------------
  // addr and wdata stay put for a whole byte time after each toggle
  always_comb begin
    s_d = s_q;
    s_d.rs1 = k_q.rd_tog;
    s_d.rs2 = s_q.rs1;
    s_d.rs3 = s_q.rs2;
    s_d.ws1 = k_q.wr_tog;
    s_d.ws2 = s_q.ws1;
    s_d.ws3 = s_q.ws2;
    rd_go   = s_q.rs2 ^ s_q.rs3;
    wr_go   = s_q.ws2 ^ s_q.ws3;
    rd_y    = rd_go && (k_q.addr == ADDR_Y);
    rd_x    = rd_go && (k_q.addr == ADDR_X);
    grab_rd = rd_go && (k_q.addr == ADDR_GRAB);
    grab_wr = wr_go && (k_q.addr == ADDR_GRAB);
    commit  = pix_valid && (s_q.pidx == PIX_LAST);
    moving  = motion_valid && ((motion_dx != RST_ZERO) || (motion_dy != RST_ZERO));

    // motion accumulation; a delta in the clearing cycle seeds the new count
    s_d.y = rd_y ? RST_ZERO : s_q.y;
    s_d.x = rd_x ? RST_ZERO : s_q.x;
    if (motion_valid) begin
      s_d.y = sat_add(s_d.y, motion_dy);
      s_d.x = sat_add(s_d.x, motion_dx);
    end

    // per-frame statistics
    if (pix_valid) begin
      s_d.pidx = commit ? PIX_FIRST : s_q.pidx + 9'h001;
      if (s_q.pidx == PIX_FIRST) begin
        s_d.run_max = pix_value;
        s_d.run_min = pix_value;
        s_d.run_sum = {9'h000, pix_value};
      end else begin
        s_d.run_max = (pix_value > s_q.run_max) ? pix_value : s_q.run_max;
        s_d.run_min = (pix_value < s_q.run_min) ? pix_value : s_q.run_min;
        s_d.run_sum = s_q.run_sum + {9'h000, pix_value};
      end
    end
    if (commit) begin
      s_d.surface = feature_total[8:1];
      s_d.peak    = s_d.run_max;
      s_d.dark    = s_d.run_min;
      s_d.total   = s_d.run_sum[14:7];
    end

    // grabber: wait for a frame start, then take the one pixel that matches
    if (pix_valid && s_q.pidx == PIX_FIRST && s_q.pend) begin
      s_d.armed = 1'b1;
      s_d.pend  = 1'b0;
    end
    if (pix_valid && s_q.pidx == s_q.gidx &&
        (s_q.armed || (s_q.pend && s_q.pidx == PIX_FIRST))) begin
      s_d.sample = pix_value;
      s_d.ready  = 1'b1;
      s_d.gfirst = (s_q.gidx == PIX_FIRST);
      s_d.armed  = 1'b0;
      s_d.pend   = 1'b0;
    end
    // an access in the capture cycle wins; the pixel is taken next frame
    if (grab_rd) begin
      if (s_q.ready) begin
        s_d.gidx = (s_q.gidx == PIX_LAST) ? PIX_FIRST : s_q.gidx + 9'h001;
      end
      s_d.ready = 1'b0;
      s_d.armed = 1'b0;
      s_d.pend  = 1'b1;
    end
    if (grab_wr) begin
      s_d.gidx  = PIX_FIRST;
      s_d.ready = 1'b0;
      s_d.armed = 1'b0;
      s_d.pend  = 1'b1;
    end

    // sleep control, counted in frames
    if (stay_active_bit || moving) begin
      s_d.awake = 1'b1;
      s_d.idle  = 11'h000;
    end else if (commit && s_q.awake) begin
      if (s_q.idle == SLEEP_FRAMES - 11'h001) begin
        s_d.awake = 1'b0;
        s_d.idle  = 11'h000;
      end else begin
        s_d.idle = s_q.idle + 11'h001;
      end
    end

    // read answer, sampled before the clear takes effect
    if (rd_go) begin
      unique case (k_q.addr)
        ADDR_STATUS:  s_d.rd_data = {PART_CODE, STAT_RSVD, s_q.awake};
        ADDR_Y:       s_d.rd_data = s_q.y;
        ADDR_X:       s_d.rd_data = s_q.x;
        ADDR_SURFACE: s_d.rd_data = s_q.surface;
        ADDR_PEAK:    s_d.rd_data = {2'b00, s_q.peak};
        ADDR_DARK:    s_d.rd_data = {2'b00, s_q.dark};
        ADDR_TOTAL:   s_d.rd_data = s_q.total;
        ADDR_GRAB:    s_d.rd_data = {s_q.gfirst & s_q.ready, s_q.ready, s_q.sample};
        default:      s_d.rd_data = UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q       <= '0;
      s_q.dark  <= RST_DARK;
      s_q.awake <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  status_read_a: assert property (rd_go && k_q.addr == ADDR_STATUS |=>
    s_q.rd_data[7:STAT_CODE_LSB] == PART_CODE && s_q.rd_data[0] == $past(s_q.awake))
    else $error("status read lost part code or awake flag");
  y_clear_a: assert property (rd_y && !motion_valid |=> s_q.y == RST_ZERO)
    else $error("y count not cleared by read");
  x_hold_a: assert property (!motion_valid && !rd_x |=> $stable(s_q.x))
    else $error("x count changed without motion or read");
  y_keep_a: assert property (rd_y && motion_valid |=> s_q.y == $past(motion_dy))
    else $error("motion lost during clear");
  sat_high_a: assert property (motion_valid && !rd_x && s_q.x == MOT_MAX && !motion_dx[7]
    |=> s_q.x == MOT_MAX) else $error("x count wrapped past 7F");
  feature_a: assert property (commit |=> s_q.surface == $past(feature_total[8:1]))
    else $error("feature count not updated at frame end");
  order_a: assert property (commit |=> s_q.dark <= s_q.peak)
    else $error("darkest above peak after frame");
  total_max_a: assert property (s_q.total <= 8'h9F)
    else $error("intensity total above 159");
  grab_restart_a: assert property (grab_wr |=> s_q.gidx == PIX_FIRST && !s_q.ready)
    else $error("grab write did not restart at pixel 1");
  grab_wrap_a: assert property (grab_rd && s_q.ready && s_q.gidx == PIX_LAST
    |=> s_q.gidx == PIX_FIRST) else $error("grabber did not wrap");
  grab_first_a: assert property (grab_rd && s_q.ready && s_q.gidx == PIX_FIRST
    |=> s_q.rd_data[GRAB_FIRST_BIT] && s_q.rd_data[GRAB_READY_BIT])
    else $error("pixel 1 returned without first flag");
  capture_a: assert property ($rose(s_q.ready) |-> $past(pix_valid))
    else $error("grab ready without a pixel");
  stay_awake_a: assert property (stay_active_bit |=> s_q.awake)
    else $error("asleep while forced active");

  // motion counts and status reserved bits
  x_clear_a: assert property (rd_x && !motion_valid
    |=> s_q.x == RST_ZERO)
    else $error("x count not cleared by read");
  y_hold_a: assert property (!motion_valid && !rd_y
    |=> $stable(s_q.y))
    else $error("y count changed without motion or read");
  x_keep_a: assert property (rd_x && motion_valid
    |=> s_q.x == $past(motion_dx))
    else $error("x motion lost during clear");
  y_read_a: assert property (rd_y
    |=> s_q.rd_data == $past(s_q.y))
    else $error("y read did not return the count");
  x_read_a: assert property (rd_x
    |=> s_q.rd_data == $past(s_q.x))
    else $error("x read did not return the count");
  y_sat_high_a: assert property (motion_valid && !rd_y &&
    s_q.y == MOT_MAX && !motion_dy[7] |=> s_q.y == MOT_MAX)
    else $error("y count wrapped past 7F");
  y_sat_low_a: assert property (motion_valid && !rd_y &&
    s_q.y == MOT_MIN && motion_dy[7] |=> s_q.y == MOT_MIN)
    else $error("y count wrapped past 80");
  x_sat_low_a: assert property (motion_valid && !rd_x &&
    s_q.x == MOT_MIN && motion_dx[7] |=> s_q.x == MOT_MIN)
    else $error("x count wrapped past 80");
  status_rsvd_a: assert property (rd_go && k_q.addr == ADDR_STATUS
    |=> s_q.rd_data[STAT_CODE_LSB-1:1] == STAT_RSVD)
    else $error("status reserved bits not zero");

  // frame statistics
  surface_read_a: assert property (rd_go && k_q.addr == ADDR_SURFACE
    |=> s_q.rd_data == $past(s_q.surface))
    else $error("feature count read mismatch");
  surface_hold_a: assert property (!commit
    |=> $stable(s_q.surface))
    else $error("feature count changed inside a frame");
  peak_read_a: assert property (rd_go && k_q.addr == ADDR_PEAK
    |=> s_q.rd_data == {2'b00, $past(s_q.peak)})
    else $error("peak read not six bits with upper bits zero");
  stats_hold_a: assert property (!commit
    |=> $stable(s_q.peak) && $stable(s_q.dark) && $stable(s_q.total))
    else $error("frame statistics changed inside a frame");
  last_pixel_a: assert property (commit
    |=> s_q.peak >= $past(pix_value) && s_q.dark <= $past(pix_value))
    else $error("last pixel outside peak and darkest");
  dark_read_a: assert property (rd_go && k_q.addr == ADDR_DARK
    |=> s_q.rd_data == {2'b00, $past(s_q.dark)})
    else $error("darkest read mismatch");
  total_read_a: assert property (rd_go && k_q.addr == ADDR_TOTAL
    |=> s_q.rd_data == $past(s_q.total))
    else $error("intensity total read mismatch");
  pix_index_a: assert property (s_q.pidx <= PIX_LAST)
    else $error("frame pixel number out of range");

  // pixel grabber
  grab_read_a: assert property (grab_rd
    |=> s_q.rd_data[GRAB_READY_BIT-1:0] == $past(s_q.sample) &&
        s_q.rd_data[GRAB_READY_BIT] == $past(s_q.ready))
    else $error("grab read returned wrong sample or ready flag");
  grab_flags_a: assert property (grab_rd
    |=> !s_q.rd_data[GRAB_FIRST_BIT] || s_q.rd_data[GRAB_READY_BIT])
    else $error("first flag without ready flag");
  grab_origin_a: assert property (s_q.ready && s_q.gfirst
    |-> s_q.gidx == PIX_FIRST)
    else $error("first flag on a pixel other than 1");
  grab_advance_a: assert property (grab_rd && s_q.ready && s_q.gidx != PIX_LAST
    |=> s_q.gidx == $past(s_q.gidx) + 9'h001)
    else $error("grabber did not advance after a valid read");
  grab_stay_a: assert property (grab_rd && !s_q.ready
    |=> $stable(s_q.gidx))
    else $error("grabber advanced past an unread pixel");
  grab_index_a: assert property (s_q.gidx <= PIX_LAST)
    else $error("grab pixel number out of range");
  grab_once_a: assert property (s_q.ready |-> !s_q.pend && !s_q.armed)
    else $error("grabber armed while holding a pixel");
  grab_arm_a: assert property (grab_rd || grab_wr
    |=> s_q.pend && !s_q.ready)
    else $error("grab access did not arm capture");
  grab_keep_a: assert property (s_q.ready && !grab_rd && !grab_wr
    |=> s_q.ready && $stable(s_q.sample))
    else $error("held pixel lost before read");

  // sleep control
  motion_wake_a: assert property (moving
    |=> s_q.awake)
    else $error("motion did not wake the sensor");
  sleep_cause_a: assert property ($fell(s_q.awake)
    |-> $past(commit) && !$past(stay_active_bit))
    else $error("fell asleep outside a frame end or while forced");
  idle_bound_a: assert property (s_q.idle < SLEEP_FRAMES)
    else $error("idle frame count out of range");

endmodule

// ---- bench/mir_host.sv ----
`timescale 1ns/10ps
// host side of the two-wire port; sck stands high between transfers
module mir_host (
  // serial port
  output logic      sck,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n
);
  logic drv = 1'b1;
  logic hv  = 1'b1;
  // a released line shows the inverse of the device's last bit, never a held copy
  assign sdio_in = !sdio_oe_n ? sdio_out : (drv ? hv : !sdio_out);
  initial sck = 1'b1;
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] fr;
    fr = {wr, a, wd};
    for (int i = 15; i >= 0; i--) begin
      sck = 1'b0;
      drv = (i > 7) || wr;
      hv = fr[i];
      #80 sck = 1'b1;
      if (i < 8) rd[i] = sdio_in;
      #80;
    end
    drv = 1'b1;
  endtask
endmodule

// ---- bench/motion_and_image_readout_regs_tb.sv ----
`timescale 1ns/10ps
module motion_and_image_readout_regs_tb;
  import mir_pkg::*;
  localparam logic [2:0] CODE = 3'h2;  // arbitrary value
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        stay = 1'b0;
  logic        pv = 1'b0;
  logic        mv = 1'b0;
  logic        sck, sdio_in, sdio_out, sdio_oe_n, awake;
  logic [5:0]  pval = 6'h00;
  logic [8:0]  feat = 9'h000;
  logic [7:0]  dx = 8'h00;
  logic [7:0]  dy = 8'h00;
  logic [7:0]  ex = 8'h00;
  logic [7:0]  ey = 8'h00;
  logic [7:0]  rd;
  logic [7:0]  ra;
  logic [5:0]  mx, mn, p0;
  logic [14:0] sm;
  logic [5:0]  fpix [324];
  int          errors = 0;
  int          check_count = 0;
  mir_readout #(.PART_CODE(CODE)) dut_u (.mclk(mclk), .rst(rst), .sck(sck),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .stay_active_bit(stay), .pix_valid(pv), .pix_value(pval), .feature_total(feat),
    .motion_valid(mv), .motion_dx(dx), .motion_dy(dy), .sensor_awake(awake));
  mir_host host_u (.sck(sck), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n));
  always #5 mclk = ~mclk;
  function automatic logic [7:0] sat(input logic [7:0] acc, input logic [7:0] d);
    int v;
    v = $signed(acc) + $signed(d);
    return v > 127 ? 8'h7F : (v < -128 ? 8'h80 : 8'(v));
  endfunction
  task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // settle time lets the register side effect land in the core domain
  task automatic rdreg(input logic [6:0] a);
    #3 host_u.xfer(1'b0, a, 8'h00, rd);
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task automatic wrreg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] u;
    #3 host_u.xfer(1'b1, a, d, u);
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task automatic rdchk(input logic [6:0] a, input string n, input logic [7:0] e);
    rdreg(a);
    check8(n, e, rd);
  endtask
  task automatic motion(input logic [7:0] x, input logic [7:0] y);
    @(posedge mclk);
    #1 mv = 1'b1;
    dx = x;
    dy = y;
    ex = sat(ex, x);
    ey = sat(ey, y);
    @(posedge mclk);
    #1 mv = 1'b0;
  endtask
  task automatic frame(input logic full);
    @(posedge mclk);
    #1 feat = full ? 9'h1FF : 9'($urandom);
    mx = 6'h00;
    mn = 6'h3F;
    sm = 15'h0000;
    for (int i = 0; i < 324; i++) begin
      fpix[i] = full ? 6'h3F : 6'($urandom);
      mx = fpix[i] > mx ? fpix[i] : mx;
      mn = fpix[i] < mn ? fpix[i] : mn;
      sm = sm + 15'(fpix[i]);
      pv = 1'b1;
      pval = fpix[i];
      @(posedge mclk);
      #1;
    end
    pv = 1'b0;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(27));
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    rdchk(ADDR_STATUS, "status", {CODE, 4'h0, 1'b1});
    rdchk(ADDR_Y, "y reset", 8'h00);
    rdchk(ADDR_X, "x reset", 8'h00);
    rdchk(ADDR_SURFACE, "surface reset", 8'h00);
    rdchk(ADDR_DARK, "dark reset", 8'h3F);
    rdchk(7'h0A, "unmapped", 8'h00);
    check8("awake", 8'h01, {7'h00, awake});
    // first round drives both counts into their limits
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 3; k++) begin
        if (r == 0) motion(8'h70, 8'h90);
        else motion(8'($urandom), 8'($urandom));
      end
      rdchk(ADDR_Y, "y count", ey);
      rdchk(ADDR_X, "x count", ex);
      ex = 8'h00;
      ey = 8'h00;
      rdchk(ADDR_Y, "y cleared", 8'h00);
      rdchk(ADDR_X, "x cleared", 8'h00);
    end
    // a delta landing in the clearing cycle must carry into the next report
    dx = 8'h00;
    fork
      rdreg(ADDR_Y);
      begin
        repeat (60) @(posedge mclk);
        #1 mv = 1'b1;
        dy = 8'h01;
        repeat (100) @(posedge mclk);
        #1 mv = 1'b0;
      end
    join
    ra = rd;
    rdreg(ADDR_Y);
    check8("y split", 8'h64, ra + rd);
    for (int f = 0; f < 2; f++) begin
      frame(f == 1);
      rdchk(ADDR_SURFACE, "surface", feat[8:1]);
      rdchk(ADDR_PEAK, "peak", {2'b00, mx});
      rdchk(ADDR_DARK, "dark", {2'b00, mn});
      rdchk(ADDR_TOTAL, "total", sm[14:7]);
    end
    stay = 1'b1;
    wrreg(ADDR_GRAB, 8'($urandom));
    frame(1'b0);
    p0 = fpix[0];
    frame(1'b0);
    rdchk(ADDR_GRAB, "grab held", {2'b11, p0});
    rdreg(ADDR_GRAB);
    check8("grab idle flags", 8'h00, rd & 8'hC0);
    for (int k = 1; k < 4; k++) begin
      frame(1'b0);
      rdchk(ADDR_GRAB, "grab next", {2'b01, fpix[k]});
    end
    wrreg(ADDR_GRAB, 8'h00);
    frame(1'b0);
    rdchk(ADDR_GRAB, "grab restart", {2'b11, fpix[0]});
    check8("awake forced", 8'h01, {7'h00, awake});
    report_and_stop();
  end
endmodule
